// ### ccvco_top.sv
/*
 * Oscillator clock path control: staged and active control registers,
 * transfer strobe, oscillator calibration sequencer and a nonvolatile
 * copy of the settings restored after reset.
 * Assumes register accesses are synchronous one-cycle strobes on ref_clk.
 */
`timescale 1ns/1ps

module ccvco_top (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [9:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic nvm_save,
	output logic [7:0] loop_control_active,
	output logic [7:0] ref_enable_active,
	output logic loop_normal,
	output logic loop_powered_down,
	output logic pfd_negative,
	output logic dist_from_osc,
	output logic post_div_bypass,
	output logic [2:0] post_div_ratio,
	output logic cal_busy,
	output logic cal_done
);

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic rst_meta_n;
	logic rst_n;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_n <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_n <= rst_meta_n;
		end
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		ccvco_pkg::ccvco_state_t state;
		logic [ccvco_pkg::NREG-1:0][7:0] staged;
		logic [ccvco_pkg::NREG-1:0][7:0] active;
		logic update;
		logic cal_busy;
		logic cal_done;
		logic [ccvco_pkg::CAL_CNT_W-1:0] cal_cnt;
		logic [7:0] rdata;
	} ccvco_regs_t;

	ccvco_regs_t st_reg;
	ccvco_regs_t st_next;

	// nonvolatile copy: survives reset, so it has none
	logic [7:0] nvm_mem [ccvco_pkg::NREG];
	logic nvm_valid;

	function automatic logic [3:0] ccvco_decode(input logic [9:0] addr);
		case (addr)
			ccvco_pkg::OFS_LOOP_CONTROL: ccvco_decode = {1'b1, ccvco_pkg::IDX_LOOP};
			ccvco_pkg::OFS_OSC_CAL: ccvco_decode = {1'b1, ccvco_pkg::IDX_CAL};
			ccvco_pkg::OFS_REF_ENABLE: ccvco_decode = {1'b1, ccvco_pkg::IDX_REF};
			ccvco_pkg::OFS_POST_DIV: ccvco_decode = {1'b1, ccvco_pkg::IDX_PDIV};
			ccvco_pkg::OFS_DIST_SELECT: ccvco_decode = {1'b1, ccvco_pkg::IDX_DIST};
			default: ccvco_decode = 4'h0;
		endcase
	endfunction : ccvco_decode

	always_ff @(posedge ref_clk) begin
		if (nvm_save) begin
			for (int i = 0; i < ccvco_pkg::NREG; i++) begin
				nvm_mem[i] <= st_reg.active[i];
			end
			nvm_valid <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [3:0] dec;
		logic cal_start;
		dec = ccvco_decode(reg_addr);
		cal_start = 1'b0;
		st_next = st_reg;
		case (st_reg.state)
			ccvco_pkg::CCVCO_LOAD: begin
				// if(X) falls to else: a never-saved store leaves defaults
				if (nvm_valid == 1'b1) begin
					for (int i = 0; i < ccvco_pkg::NREG; i++) begin
						st_next.staged[i] = nvm_mem[i];
						st_next.active[i] = nvm_mem[i];
					end
				end
				st_next.state = ccvco_pkg::CCVCO_RUN;
			end
			ccvco_pkg::CCVCO_RUN: begin
				// transfer first so a strobe written now is not lost
				if (st_reg.update) begin
					st_next.active = st_reg.staged;
					st_next.update = 1'b0;
					// only a 0 to 1 edge of the request starts a run
					cal_start = st_reg.staged[ccvco_pkg::IDX_CAL][ccvco_pkg::CAL_REQ_BIT]
						&& !st_reg.active[ccvco_pkg::IDX_CAL][ccvco_pkg::CAL_REQ_BIT];
				end
				if (reg_wr && dec[3]) begin
					st_next.staged[dec[2:0]] = reg_wdata;
				end
				if (reg_wr && reg_addr == ccvco_pkg::OFS_UPDATE
					&& reg_wdata[ccvco_pkg::UPDATE_BIT]) begin
					st_next.update = 1'b1;
				end
			end
			default: begin
				st_next.state = ccvco_pkg::CCVCO_LOAD;
			end
		endcase

		// clear first: a run ending in the same cycle keeps its done flag
		if (st_reg.update
			&& !st_reg.staged[ccvco_pkg::IDX_CAL][ccvco_pkg::CAL_REQ_BIT]) begin
			st_next.cal_done = 1'b0;
		end
		if (cal_start) begin
			st_next.cal_busy = 1'b1;
			st_next.cal_done = 1'b0;
			st_next.cal_cnt = ccvco_pkg::CAL_CNT_W'(ccvco_pkg::CAL_CYCLES - 1);
		end else if (st_reg.cal_busy) begin
			if (st_reg.cal_cnt == '0) begin
				st_next.cal_busy = 1'b0;
				st_next.cal_done = 1'b1;
			end else begin
				st_next.cal_cnt = st_reg.cal_cnt - 1'b1;
			end
		end

		if (reg_rd) begin
			if (dec[3]) begin
				st_next.rdata = st_reg.staged[dec[2:0]];
			end else if (reg_addr == ccvco_pkg::OFS_UPDATE) begin
				st_next.rdata = {7'h00, st_reg.update};
			end else begin
				st_next.rdata = 8'h00;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg.state <= ccvco_pkg::CCVCO_LOAD;
			st_reg.staged <= '0;
			st_reg.staged[ccvco_pkg::IDX_LOOP] <= ccvco_pkg::RST_LOOP_CONTROL;
			st_reg.active <= '0;
			st_reg.active[ccvco_pkg::IDX_LOOP] <= ccvco_pkg::RST_LOOP_CONTROL;
			st_reg.update <= 1'b0;
			st_reg.cal_busy <= 1'b0;
			st_reg.cal_done <= 1'b0;
			st_reg.cal_cnt <= '0;
			st_reg.rdata <= ccvco_pkg::RST_OTHER;
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	logic [1:0] loop_mode;
	logic [2:0] pdiv_code;

	assign loop_mode = st_reg.active[ccvco_pkg::IDX_LOOP][ccvco_pkg::LOOP_MODE_LSB +: 2];
	assign pdiv_code = st_reg.active[ccvco_pkg::IDX_PDIV][ccvco_pkg::POST_DIV_W-1:0];
	assign reg_rdata = st_reg.rdata;
	assign loop_control_active = st_reg.active[ccvco_pkg::IDX_LOOP];
	assign ref_enable_active = st_reg.active[ccvco_pkg::IDX_REF];
	assign loop_normal = (loop_mode == ccvco_pkg::LOOP_MODE_NORMAL);
	assign loop_powered_down = (loop_mode == ccvco_pkg::LOOP_MODE_ASYNC_DOWN);
	assign pfd_negative = st_reg.active[ccvco_pkg::IDX_LOOP][ccvco_pkg::PFD_POL_BIT];
	// 1: oscillator, 0: external clock input
	assign dist_from_osc = st_reg.active[ccvco_pkg::IDX_DIST][ccvco_pkg::DIST_OSC_BIT];
	// 0: through post-divider, 1: bypassed
	assign post_div_bypass = st_reg.active[ccvco_pkg::IDX_DIST][ccvco_pkg::DIST_BYPASS_BIT];
	// codes above 101b wrap; software keeps to the legal ratios
	assign post_div_ratio = pdiv_code + ccvco_pkg::POST_DIV_OFFSET;
	assign cal_busy = st_reg.cal_busy;
	assign cal_done = st_reg.cal_done;

endmodule : ccvco_top

// ### ccvco_pkg.sv
/*
 * Constants for the oscillator clock path control block: register offsets,
 * field positions, reset values, calibration timing and state codes.
 * Assumes a single 20 MHz control clock.
 */
package ccvco_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 10;
	localparam logic [9:0] OFS_LOOP_CONTROL = 10'h010;
	localparam logic [9:0] OFS_OSC_CAL = 10'h018;
	localparam logic [9:0] OFS_REF_ENABLE = 10'h01C;
	localparam logic [9:0] OFS_POST_DIV = 10'h1E0;
	localparam logic [9:0] OFS_DIST_SELECT = 10'h1E1;
	localparam logic [9:0] OFS_UPDATE = 10'h232;

	// ----------------------------------------------------------------
	// fields and reset values
	// ----------------------------------------------------------------
	localparam int LOOP_MODE_LSB = 0;
	localparam logic [1:0] LOOP_MODE_NORMAL = 2'h0;
	localparam logic [1:0] LOOP_MODE_ASYNC_DOWN = 2'h1;
	localparam int PFD_POL_BIT = 7;
	localparam int CAL_REQ_BIT = 0;
	localparam int DIST_BYPASS_BIT = 0;
	localparam int DIST_OSC_BIT = 1;
	localparam int UPDATE_BIT = 0;
	localparam int POST_DIV_W = 3;
	localparam logic [2:0] POST_DIV_OFFSET = 3'h2;
	localparam logic [7:0] RST_LOOP_CONTROL = 8'h01;
	localparam logic [7:0] RST_OTHER = 8'h00;
	localparam int NREG = 5;
	localparam logic [2:0] IDX_LOOP = 3'h0;
	localparam logic [2:0] IDX_CAL = 3'h1;
	localparam logic [2:0] IDX_REF = 3'h2;
	localparam logic [2:0] IDX_PDIV = 3'h3;
	localparam logic [2:0] IDX_DIST = 3'h4;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int CAL_TIME_US = 100;
	localparam int CAL_CYCLES = (CAL_TIME_US * 1000) / CLK_PERIOD_NS;
	localparam int CAL_CNT_W = 12;

	typedef enum logic [1:0] {
		CCVCO_LOAD = 2'b00,
		CCVCO_RUN = 2'b01
	} ccvco_state_t;

endpackage : ccvco_pkg

// ### ccvco_top_sva.sv
/* Port assertions for ccvco_top.
 * Assumes one rising-edge clock and nrst active low. */
`timescale 1ns/1ps
module ccvco_top_sva (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [9:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [7:0] loop_control_active,
	input wire logic loop_normal,
	input wire logic loop_powered_down,
	input wire logic pfd_negative,
	input wire logic dist_from_osc,
	input wire logic post_div_bypass,
	input wire logic [2:0] post_div_ratio,
	input wire logic cal_busy,
	input wire logic cal_done
);
	logic [2:0] rel_reg;
	logic [11:0] busy_reg;
	logic upd;
	logic ok;
	assign upd = reg_wr && reg_addr == ccvco_pkg::OFS_UPDATE && reg_wdata[0];
	// restore cycle after release may move outputs
	assign ok = rel_reg == 3'h7;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rel_reg <= 3'h0;
			busy_reg <= 12'h000;
		end else begin
			rel_reg <= ok ? rel_reg : rel_reg + 3'h1;
			busy_reg <= cal_busy ? busy_reg + 12'h001 : 12'h000;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	loop_on_a: assert property (loop_normal == (loop_control_active[1:0] == 2'h0))
		else $error("loop normal decode");
	loop_down_a: assert property (loop_powered_down == (loop_control_active[1:0] == 2'h1))
		else $error("loop down decode");
	reset_val_a: assert property ($rose(nrst) |-> loop_powered_down && post_div_ratio == 3'h2)
		else $error("reset values");
	strobe_only_a: assert property ($changed({loop_control_active, dist_from_osc, post_div_bypass,
		post_div_ratio}) && ok |-> $past(upd, 2))
		else $error("change without strobe");
	cal_start_a: assert property ($rose(cal_busy) && ok |-> $past(upd, 2) || $past(upd, 3))
		else $error("calibration start");
	cal_span_a: assert property ($rose(cal_done) |-> busy_reg == 12'h7D0)
		else $error("calibration length");
	pfd_pol_a: assert property (pfd_negative == loop_control_active[7])
		else $error("pfd polarity");
	unmapped_a: assert property (reg_rd && reg_addr == 10'h3FF |=> reg_rdata == 8'h00)
		else $error("unmapped read");
	cover property ($rose(cal_done));
	cover property ($rose(dist_from_osc));
	cover property ($rose(post_div_bypass));
endmodule : ccvco_top_sva
bind ccvco_top ccvco_top_sva u_ccvco_top_sva (
	.ref_clk(ref_clk),
	.nrst(nrst),
	.reg_addr(reg_addr),
	.reg_wr(reg_wr),
	.reg_wdata(reg_wdata),
	.reg_rd(reg_rd),
	.reg_rdata(reg_rdata),
	.loop_control_active(loop_control_active),
	.loop_normal(loop_normal),
	.loop_powered_down(loop_powered_down),
	.pfd_negative(pfd_negative),
	.dist_from_osc(dist_from_osc),
	.post_div_bypass(post_div_bypass),
	.post_div_ratio(post_div_ratio),
	.cal_busy(cal_busy),
	.cal_done(cal_done)
);

// ### tb_ccvco_top.sv
/* Bench for ccvco_top.
 * Assumes ccvco_pkg and the checker are compiled first. */
`timescale 1ns/1ps
module tb_ccvco_top;
	logic ref_clk, nrst, reg_wr, reg_rd, nvm_save, rd_d;
	logic loop_normal, loop_powered_down, pfd_negative, dist_from_osc, post_div_bypass;
	logic cal_busy, cal_done;
	logic [9:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, loop_control_active, ref_enable_active, exp_q[$];
	logic [2:0] post_div_ratio;
	int fail_count, checks_done, seed, n;
	ccvco_top u_ccvco_top (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.reg_addr(reg_addr),
		.reg_wr(reg_wr),
		.reg_wdata(reg_wdata),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.nvm_save(nvm_save),
		.loop_control_active(loop_control_active),
		.ref_enable_active(ref_enable_active),
		.loop_normal(loop_normal),
		.loop_powered_down(loop_powered_down),
		.pfd_negative(pfd_negative),
		.dist_from_osc(dist_from_osc),
		.post_div_bypass(post_div_bypass),
		.post_div_ratio(post_div_ratio),
		.cal_busy(cal_busy),
		.cal_done(cal_done)
	);
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] want);
		checks_done++;
		if (seen !== want) begin
			fail_count++;
			$display("CHECK FAILED %0t seen %h want %h", $time, seen, want);
		end
	endtask : chk
	task automatic close_out;
		$display("fail_count %0d checks_done %0d", fail_count, checks_done);
		if (fail_count == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out
	always @(posedge ref_clk) begin
		rd_d <= reg_rd;
		if (rd_d === 1'b1) chk(reg_rdata, exp_q.pop_front());
	end
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [9:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		exp_q.push_back(e);
		@(posedge ref_clk);
		reg_rd <= 1'b0;
	endtask : rd
	task automatic upd;
		wr(ccvco_pkg::OFS_UPDATE, 8'h01);
		@(posedge ref_clk);
		#1;
	endtask : upd
	task automatic rst;
		nrst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (4) @(posedge ref_clk);
		#1;
	endtask : rst
	task automatic cal_run;
		wr(ccvco_pkg::OFS_OSC_CAL, 8'h01);
		upd();
		chk(cal_busy, 1'b1);
		n = 0;
		while (cal_done !== 1'b1 && n < 2100) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		chk(16'(n), 16'(ccvco_pkg::CAL_CYCLES));
	endtask : cal_run
	initial begin
		repeat (20000) @(posedge ref_clk);
		fail_count++;
		close_out();
	end
	initial begin
		{nrst, reg_wr, reg_rd, nvm_save} = 4'h0;
		reg_addr = 10'h000;
		reg_wdata = 8'h00;
		seed = 61484;
		rst();
		chk({loop_powered_down, loop_normal, post_div_ratio}, 5'h12);
		rd(ccvco_pkg::OFS_LOOP_CONTROL, 8'h01);
		rd(ccvco_pkg::OFS_POST_DIV, 8'h00);
		rd(10'h3FF, 8'h00);
		wr(ccvco_pkg::OFS_DIST_SELECT, 8'h02);
		wr(ccvco_pkg::OFS_LOOP_CONTROL, 8'h80);
		rd(ccvco_pkg::OFS_DIST_SELECT, 8'h02);
		chk({dist_from_osc, pfd_negative, loop_powered_down}, 3'h1);
		upd();
		chk({dist_from_osc, post_div_bypass, pfd_negative, loop_normal}, 4'hB);
		rd(ccvco_pkg::OFS_UPDATE, 8'h00);
		n = $random(seed);
		wr(ccvco_pkg::OFS_DIST_SELECT, 8'h01);
		wr(ccvco_pkg::OFS_POST_DIV, n[7:0]);
		wr(ccvco_pkg::OFS_REF_ENABLE, n[15:8]);
		wr(ccvco_pkg::OFS_LOOP_CONTROL, 8'h01);
		upd();
		chk({dist_from_osc, post_div_bypass, loop_powered_down}, 3'h3);
		chk(post_div_ratio, 3'(n[2:0] + 3'h2));
		chk(ref_enable_active, n[15:8]);
		cal_run();
		// request already active must not restart
		upd();
		chk({cal_busy, cal_done}, 2'h1);
		wr(ccvco_pkg::OFS_OSC_CAL, 8'h00);
		upd();
		chk(cal_done, 1'b0);
		cal_run();
		// oscillator feeds the outputs: calibration request stays set
		wr(ccvco_pkg::OFS_OSC_CAL, 8'h01);
		wr(ccvco_pkg::OFS_DIST_SELECT, 8'h02);
		wr(ccvco_pkg::OFS_LOOP_CONTROL, 8'h80);
		upd();
		chk({cal_busy, cal_done, post_div_bypass}, 3'h2);
		@(posedge ref_clk);
		nvm_save <= 1'b1;
		@(posedge ref_clk);
		nvm_save <= 1'b0;
		rst();
		#1;
		chk({dist_from_osc, pfd_negative, loop_normal}, 3'h7);
		repeat (3) @(posedge ref_clk);
		close_out();
	end
endmodule : tb_ccvco_top
